//--- rtl/adc_ctrl_pkg.sv
// adc_ctrl_pkg: register map, field layout and timing constants for the converter control block
// assumes a 32-bit apb slave with one register per aligned word
package adc_ctrl_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned RES_W = 8;
    localparam int unsigned CH_W = 2;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned TS_W = 3;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFS_DIDR = 8'h17 << 2;
    localparam logic [ADDR_W-1:0] OFS_MUX = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL_A = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CTRL_B = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_POWER = 8'h10;

    // control a fields
    localparam int unsigned CA_EN = 7;
    localparam int unsigned CA_SC = 6;
    localparam int unsigned CA_ATE = 5;
    localparam int unsigned CA_IF = 4;
    localparam int unsigned CA_IE = 3;
    localparam int unsigned CA_PS_LO = 0;
    localparam int unsigned PS_W = 3;
    localparam int unsigned PWR_OFF_BIT = 0;

    localparam logic [7:0] DIDR_RESET = 8'h00;
    localparam logic [3:0] DIDR_MASK = 4'hF;

    localparam int unsigned CYC_NORMAL = 13;
    localparam int unsigned CYC_FIRST = 25;
    localparam int unsigned CNT_W = 5;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_CONV = 3'b100
    } conv_state_t;
endpackage

//--- rtl/adc_prescaler.sv
// adc_prescaler: divides the system clock into a one-cycle converter clock enable
// assumes the divider is held cleared whenever i_clear is high
`timescale 1ns/1ps
module adc_prescaler import adc_ctrl_pkg::*; #(
    parameter int unsigned DIV_W = 7
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_clear,
    input wire logic [PS_W-1:0] i_select,
    output logic o_tick
);
    logic [DIV_W-1:0] count_q;
    logic [DIV_W-1:0] limit;

    // ratio is 2 to the power of the select field, minimum 2
    always_comb begin
        limit = DIV_W'((1 << ((i_select == '0) ? 1 : i_select)) - 1);
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b || i_clear) begin
            count_q <= '0;
            o_tick <= 1'b0;
        end else if (count_q >= limit) begin
            count_q <= '0;
            o_tick <= 1'b1;
        end else begin
            count_q <= count_q + DIV_W'(1);
            o_tick <= 1'b0;
        end
    end
endmodule // adc_prescaler

//--- rtl/adc_conversion_control.sv
// adc_conversion_control: sequencing, triggering and register file of an 8-bit sar converter
// assumes apb master, synchronous analog comparator input and synchronous trigger events
`timescale 1ns/1ps
module adc_conversion_control import adc_ctrl_pkg::*; #(
    parameter int unsigned NUM_TRIG = 8,
    parameter int unsigned FREE_RUN_SRC = 0
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire apb_req_t i_apb,
    output apb_rsp_t o_apb,
    input wire logic [NUM_TRIG-1:0] i_trig_events,
    input wire logic i_global_irq_en,
    input wire logic i_cmp_above,
    input wire logic [NUM_CH-1:0] i_pin_in,
    output logic [NUM_CH-1:0] o_pin_read,
    output logic [NUM_CH-1:0] o_buf_disable,
    output logic [CH_W-1:0] o_channel,
    output logic o_analog_on,
    output logic o_sample,
    output logic [RES_W-1:0] o_dac,
    output logic o_irq
);
    logic [7:0] didr_q;
    logic [CH_W-1:0] mux_q;
    logic [CH_W-1:0] chan_q;
    logic en_q;
    logic sc_q;
    logic ate_q;
    logic if_q;
    logic ie_q;
    logic [PS_W-1:0] ps_q;
    logic [TS_W-1:0] ts_q;
    logic pwr_off_q;
    logic [RES_W-1:0] result_q;
    logic [RES_W-1:0] sar_q;
    logic [CNT_W-1:0] cyc_q;
    logic first_q;
    logic trig_prev_q;
    logic single_q;
    conv_state_t state_q;
    logic tick;
    logic wr;
    logic rd;
    logic sel_trig;
    logic trig_edge;
    logic sc_write;
    logic if_write_one;
    logic done;
    logic busy;
    logic [CNT_W-1:0] total;
    logic [RES_W-1:0] trial;
    logic wr_didr;
    logic wr_mux;
    logic wr_ctrl_a;
    logic wr_ctrl_b;
    logic wr_power;
    logic free_run;
    logic decide_win;
    logic sample_win;
    logic [CNT_W-1:0] decide_start;
    logic [31:0] rdata_d;
    logic [NUM_CH-1:0] buf_off_d;

    assign wr = i_apb.psel && i_apb.penable && i_apb.pwrite;
    assign rd = i_apb.psel && !i_apb.penable && !i_apb.pwrite;
    assign busy = (state_q != ST_IDLE);

    // one write strobe per writable register word; the result word has none
    assign wr_didr = wr && (i_apb.paddr == OFS_DIDR);
    assign wr_mux = wr && (i_apb.paddr == OFS_MUX);
    assign wr_ctrl_a = wr && (i_apb.paddr == OFS_CTRL_A);
    assign wr_ctrl_b = wr && (i_apb.paddr == OFS_CTRL_B);
    assign wr_power = wr && (i_apb.paddr == OFS_POWER);
    // completion flag selected as trigger keeps the converter running
    assign free_run = ate_q && (32'(ts_q) == FREE_RUN_SRC);

    // trigger mux over event vector, completion flag as free-running source
    always_comb begin
        sel_trig = 1'b0;
        if (32'(ts_q) < NUM_TRIG) begin
            sel_trig = i_trig_events[ts_q];
        end
        if (32'(ts_q) == FREE_RUN_SRC) begin
            sel_trig = if_q;
        end
    end

    // edge only counts when idle; edges during conversion are dropped
    assign trig_edge = en_q && ate_q && sel_trig && !trig_prev_q && !busy;
    assign sc_write = wr_ctrl_a && i_apb.pwdata[CA_SC]
        && i_apb.pwdata[CA_EN] && !pwr_off_q;
    assign if_write_one = wr_ctrl_a && i_apb.pwdata[CA_IF];
    assign total = CNT_W'(first_q ? CYC_FIRST : CYC_NORMAL);
    assign done = (state_q == ST_CONV) && tick && (cyc_q == total - CNT_W'(1));
    // the last RES_W converter clocks before completion decide one bit each
    assign decide_start = total - CNT_W'(RES_W + 1);
    assign decide_win = (cyc_q >= decide_start) && (cyc_q < total - CNT_W'(1));
    assign sample_win = (cyc_q < decide_start);
    assign trial = sar_q | (RES_W'(1) << (RES_W - 1 - int'(cyc_q - decide_start)));

    adc_prescaler #(
        .DIV_W(7)
    ) u_prescaler (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_clear(!en_q || trig_edge),
        .i_select(ps_q),
        .o_tick(tick)
    );

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            trig_prev_q <= 1'b0;
        end else begin
            // level held through completion gives no new edge
            trig_prev_q <= sel_trig;
        end
    end

    // digital input disable: only the four pin bits are stored
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            didr_q <= DIDR_RESET;
        end else if (wr_didr) begin
            didr_q <= {4'h0, i_apb.pwdata[3:0] & DIDR_MASK};
        end
    end

    // channel request; the channel latch below applies it to the converter
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            mux_q <= '0;
        end else if (wr_mux) begin
            mux_q <= i_apb.pwdata[CH_W-1:0];
        end
    end

    // control a; enable cannot be set while the power-off bit is one
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            en_q <= 1'b0;
            ate_q <= 1'b0;
            ie_q <= 1'b0;
            ps_q <= '0;
        end else if (wr_ctrl_a) begin
            en_q <= i_apb.pwdata[CA_EN] && !pwr_off_q;
            ate_q <= i_apb.pwdata[CA_ATE];
            ie_q <= i_apb.pwdata[CA_IE];
            ps_q <= i_apb.pwdata[CA_PS_LO +: PS_W];
        end
    end

    // control b: trigger source select
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            ts_q <= '0;
        end else if (wr_ctrl_b) begin
            ts_q <= i_apb.pwdata[TS_W-1:0];
        end
    end

    // power-off bit comes out of reset set, so the converter starts unpowered
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            pwr_off_q <= 1'b1;
        end else if (wr_power) begin
            pwr_off_q <= i_apb.pwdata[PWR_OFF_BIT];
        end
    end

    // conversion sequencer
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            state_q <= ST_IDLE;
            cyc_q <= '0;
            sar_q <= '0;
            first_q <= 1'b1;
            single_q <= 1'b0;
        end else if (!en_q) begin
            // enable and start written together: the start is kept, not lost
            state_q <= sc_write ? ST_WAIT : ST_IDLE;
            single_q <= sc_write;
            first_q <= 1'b1;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (trig_edge) begin
                        state_q <= ST_WAIT;
                        single_q <= 1'b0;
                    end else if (sc_write) begin
                        state_q <= ST_WAIT;
                        single_q <= 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (tick) begin
                        state_q <= ST_CONV;
                        cyc_q <= '0;
                        sar_q <= '0;
                    end
                end
                ST_CONV: begin
                    if (tick) begin
                        cyc_q <= cyc_q + CNT_W'(1);
                        if (decide_win) begin
                            // keep trial bit when input is above the dac level
                            sar_q <= i_cmp_above ? trial : sar_q;
                        end
                        if (done) begin
                            first_q <= 1'b0;
                            // free-running: flag source restarts at once
                            state_q <= free_run ? ST_WAIT : ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // result word, loaded only at completion
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            result_q <= '0;
        end else if (done) begin
            result_q <= sar_q;
        end
    end

    // start bit doubles as busy; free-running keeps it high across completion
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            sc_q <= 1'b0;
        end else begin
            sc_q <= (busy && !done) || (state_q == ST_IDLE && (sc_write || trig_edge))
                || (done && free_run);
        end
    end

    // completion flag: set by completion, cleared by writing one; the set wins
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            if_q <= 1'b0;
        end else if (done) begin
            if_q <= 1'b1;
        end else if (if_write_one) begin
            if_q <= 1'b0;
        end
    end

    // channel latched while enabled and not converting (idle or waiting), and on the completion tick
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            chan_q <= '0;
        end else if (en_q && (state_q != ST_CONV || done)) begin
            chan_q <= mux_q;
        end
    end

    // read data for the word addressed in the setup cycle; unmapped words read zero
    always_comb begin
        unique case (i_apb.paddr)
            OFS_DIDR: rdata_d = {24'h0, didr_q};
            OFS_MUX: rdata_d = {30'h0, mux_q};
            OFS_CTRL_A: rdata_d = {24'h0, en_q, sc_q, ate_q, if_q, ie_q, ps_q};
            OFS_CTRL_B: rdata_d = {29'h0, ts_q};
            OFS_RESULT: rdata_d = {24'h0, result_q};
            OFS_POWER: rdata_d = {31'h0, pwr_off_q};
            default: rdata_d = '0;
        endcase
    end

    // ready answers the setup cycle, so every access phase lasts one clock
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_apb <= '0;
        end else begin
            o_apb.pready <= i_apb.psel && !i_apb.penable;
            o_apb.pslverr <= 1'b0;
            if (rd) begin
                o_apb.prdata <= rdata_d;
            end
        end
    end

    // comparator pair shares bit 0, the other pins follow their own bit
    assign buf_off_d = {didr_q[3:2], didr_q[1] | didr_q[0], didr_q[0]};

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_buf_disable <= '0;
            o_pin_read <= '0;
        end else begin
            o_buf_disable <= buf_off_d;
            // a disabled buffer reads zero, the comparator pair included
            o_pin_read <= i_pin_in & ~buf_off_d;
        end
    end

    // converter side: interrupt, channel, power, sample phase and dac trial code
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
            o_channel <= '0;
            o_analog_on <= 1'b0;
            o_sample <= 1'b0;
            o_dac <= '0;
        end else begin
            o_irq <= if_q && ie_q && i_global_irq_en;
            o_channel <= chan_q;
            o_analog_on <= en_q;
            // gated by enable so sampling never outlives a disable write
            o_sample <= en_q && (state_q == ST_CONV) && sample_win;
            o_dac <= (state_q == ST_CONV) ? trial : '0;
        end
    end
endmodule // adc_conversion_control

//--- testbench/adc_analog_model.sv
// adc_analog_model: analog levels on the four converter pins behind the channel multiplexer
// assumes the dac code and channel come straight from the block's registered outputs
`timescale 1ns/1ps
module adc_analog_model import adc_ctrl_pkg::*; (
    input wire logic [NUM_CH-1:0][RES_W-1:0] i_levels,
    input wire logic [CH_W-1:0] i_channel,
    input wire logic [RES_W-1:0] i_dac,
    output logic o_cmp_above,
    output logic [NUM_CH-1:0] o_pin
);
    // a trial code at or below the pin level keeps its bit
    assign o_cmp_above = i_levels[i_channel] >= i_dac;
    // digital buffer sees a pin as high from mid-supply up
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            o_pin[i] = i_levels[i][RES_W-1];
        end
    end
endmodule // adc_analog_model

//--- testbench/adc_conversion_control_properties.sv
// adc_conversion_control_properties: port-level checks of the converter control block
// assumes it is bound to the block and sees only its ports
`timescale 1ns/1ps
module adc_conversion_control_properties import adc_ctrl_pkg::*; #(
    parameter int unsigned NUM_TRIG = 8
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire apb_req_t i_apb,
    input wire apb_rsp_t o_apb,
    input wire logic [NUM_TRIG-1:0] i_trig_events,
    input wire logic i_global_irq_en,
    input wire logic [NUM_CH-1:0] o_pin_read,
    input wire logic [NUM_CH-1:0] o_buf_disable,
    input wire logic [CH_W-1:0] o_channel,
    input wire logic o_analog_on,
    input wire logic o_sample,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    a_no_slverr: assert property (o_apb.pready |-> !o_apb.pslverr)
        else $error("slave error raised");
    a_ready_access: assert property (o_apb.pready |-> i_apb.psel && i_apb.penable)
        else $error("ready outside access phase");
    a_setup_answer: assert property (i_apb.psel && !i_apb.penable |=> o_apb.pready)
        else $error("no ready after setup");
    a_pin_masked: assert property ((o_pin_read & o_buf_disable) == '0)
        else $error("disabled pin reads high");
    a_cmp_pair: assert property (o_buf_disable[0] |-> o_buf_disable[1])
        else $error("comparator pin buffer left on");
    a_irq_cause: assert property (o_irq |-> $past(i_global_irq_en))
        else $error("interrupt without global enable");
    a_chan_lock: assert property (o_sample && $past(o_sample) |-> $stable(o_channel))
        else $error("channel moved while sampling");
    a_off_idle: assert property (!o_analog_on |-> !o_sample)
        else $error("sampling while disabled");
    c_sample: cover property ($rose(o_sample));
    c_irq: cover property ($rose(o_irq));
    c_enable: cover property ($rose(o_analog_on));
endmodule // adc_conversion_control_properties
bind adc_conversion_control adc_conversion_control_properties #(.NUM_TRIG(NUM_TRIG)) props_i (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_apb(i_apb), .o_apb(o_apb),
    .i_trig_events(i_trig_events), .i_global_irq_en(i_global_irq_en),
    .o_pin_read(o_pin_read), .o_buf_disable(o_buf_disable), .o_channel(o_channel),
    .o_analog_on(o_analog_on), .o_sample(o_sample), .o_irq(o_irq));

//--- testbench/tb.sv
// tb: random and corner-case register, conversion and trigger scenarios
// assumes the apb slave answers in the access cycle and the analog model sits on the pins
`timescale 1ns/1ps
module tb;
    import adc_ctrl_pkg::*;
    logic clock = 0, rst_b = 0, gie = 0, cmp, aon, smp, irq;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    logic [7:0] trig = '0, dac;
    logic [3:0] pin, pin_rd, bdis, d;
    logic [1:0] ch;
    logic [3:0][7:0] lvl;
    logic [31:0] q;
    int seed = 29118, errors = 0, n_checks = 0, cyc = 0, t;
    initial forever #2.5 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    adc_conversion_control adc_conversion_control_i (.i_clock(clock), .i_rst_b(rst_b),
        .i_apb(req), .o_apb(rsp), .i_trig_events(trig), .i_global_irq_en(gie),
        .i_cmp_above(cmp), .i_pin_in(pin), .o_pin_read(pin_rd), .o_buf_disable(bdis),
        .o_channel(ch), .o_analog_on(aon), .o_sample(smp), .o_dac(dac), .o_irq(irq));
    adc_analog_model adc_analog_model_i (.i_levels(lvl), .i_channel(ch), .i_dac(dac),
        .o_cmp_above(cmp), .o_pin(pin));
    task automatic finish_test();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
        int n;
        @(posedge clock);
        req.paddr <= a; req.pwrite <= w; req.pwdata <= wd; req.psel <= 1'b1;
        @(posedge clock);
        req.penable <= 1'b1;
        n = 0;
        // ready, read data and the write all belong to the edge that samples ready high
        do begin
            @(posedge clock);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1) begin errors++; finish_test(); end
        q = rsp.prdata;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wait_idle(output int dt);
        int t0 = cyc, n = 0;
        do begin bus(OFS_CTRL_A, 0, 0); n++; end while (q[CA_SC] && n < 300);
        if (n == 300) begin errors++; finish_test(); end
        dt = cyc - t0;
    endtask
    task automatic convert(input logic [1:0] c, output int dt);
        bus(OFS_MUX, 1, {30'h0, c});
        bus(OFS_CTRL_A, 1, 32'hC0);
        wait_idle(dt);
        bus(OFS_RESULT, 0, 0); chk("result", q, {24'h0, lvl[c]});
    endtask
    initial begin
        for (int i = 0; i < 4; i++) lvl[i] = 8'($random(seed));
        lvl[0] = 8'h00; lvl[3] = 8'hFF;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        bus(OFS_DIDR, 0, 0); chk("didr_reset", q, {24'h0, DIDR_RESET});
        d = 4'($random(seed));
        bus(OFS_DIDR, 1, {28'h0, d}); bus(OFS_DIDR, 0, 0);
        chk("didr", q, {28'h0, d});
        chk("buf_off", bdis, d | {2'b0, d[0], 1'b0});
        chk("pin_read", pin_rd, pin & ~(d | {2'b0, d[0], 1'b0}));
        bus(8'h20, 0, 0); chk("unmapped", q, 0);
        bus(OFS_POWER, 1, 0);
        convert(2'd2, t); chk("first_long", t >= 2 * CYC_FIRST, 1);
        bus(OFS_MUX, 1, 32'h3); bus(OFS_CTRL_A, 1, 32'hC0); bus(OFS_MUX, 1, 32'h0);
        wait_idle(t); chk("normal_len", t >= 2 * CYC_NORMAL && t < 2 * CYC_FIRST, 1);
        bus(OFS_RESULT, 0, 0); chk("old_channel", q, {24'h0, lvl[3]});
        bus(OFS_CTRL_A, 0, 0); chk("flag", q[CA_IF], 1);
        gie <= 1'b1;
        bus(OFS_CTRL_A, 1, 32'h88); repeat (2) @(posedge clock);
        chk("irq_on", irq, 1);
        bus(OFS_CTRL_A, 1, 32'h98); repeat (2) @(posedge clock);
        chk("irq_off", irq, 0);
        bus(OFS_CTRL_B, 1, 32'h1); bus(OFS_CTRL_A, 1, 32'hA0);
        trig[1] <= 1'b1; repeat (4) @(posedge clock);
        bus(OFS_CTRL_A, 0, 0); chk("trig_busy", q[CA_SC], 1);
        trig[1] <= 1'b0; @(posedge clock); trig[1] <= 1'b1;
        wait_idle(t); bus(OFS_RESULT, 0, 0); chk("trig_res", q, {24'h0, lvl[0]});
        repeat (80) @(posedge clock);
        bus(OFS_CTRL_A, 0, 0); chk("no_restart", q[CA_SC], 0);
        trig[1] <= 1'b0;
        bus(OFS_CTRL_A, 1, 32'hF0); wait_idle(t);
        chk("sc_under_ate", t > 2 * CYC_NORMAL, 1);
        bus(OFS_CTRL_B, 1, 32'h0); bus(OFS_CTRL_A, 1, 32'hE0);
        repeat (60) @(posedge clock); bus(OFS_CTRL_A, 1, 32'hB0);
        repeat (120) @(posedge clock);
        bus(OFS_CTRL_A, 0, 0); chk("free_run", q[CA_SC], 1);
        bus(OFS_CTRL_A, 1, 32'h80); wait_idle(t);
        for (int k = 0; k < 4; k++) convert(2'($random(seed)), t);
        finish_test();
    end
endmodule // tb
